//--- src/tx_ctl_pkg.sv
// Package: register map, field positions, reset values and timing counts of the transmit control block
package tx_ctl_pkg;
   // Register byte addresses (printed offset is a word index)
   localparam logic [7:0] IDX_TX_CTL = 8'h03;
   localparam logic [7:0] ADDR_TX_CTL = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
   localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h14;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;
   localparam logic [7:0] ADDR_TX_CMD = 8'h1c;
   localparam logic [7:0] ADDR_DESC_STATUS = 8'h20;
   // Field positions
   localparam int B_PROGRAMMABLE_TX_INTERRUPT = 15;
   localparam int B_WINORG = 14;
   localparam int B_FCSI = 13;
   localparam int B_DEFDIS = 12;
   localparam int B_EXDEF = 10;
   localparam int B_DEFER = 9;
   localparam int B_NOCRS = 8;
   localparam int B_CRSLOST = 7;
   localparam int B_EXCOL = 6;
   localparam int B_LATE = 5;
   localparam int B_MONBAD = 3;
   localparam int B_UNDER = 2;
   localparam int B_BCNT = 1;
   localparam int B_TXOK = 0;
   localparam logic [15:0] MODE_MASK = 16'hf000;
   localparam logic [15:0] STAT_MASK = 16'h07ef;
   localparam logic [15:0] TX_CTL_RESET = 16'h0101;
   localparam logic [15:0] CLR_AFTER_WB = 16'h0220;
   localparam logic [15:0] CLR_AT_START = 16'h04c2;
   localparam logic [15:0] SET_AT_START = 16'h0100;
   // Interrupt status layout
   localparam int I_PROGRAMMABLE_TX_INTERRUPT = 0;
   localparam int I_DONE = 1;
   localparam int I_ABORT = 2;
   localparam int N_IRQ = 3;
   // Timing
   localparam int CLK_HZ = 50000000;
   localparam int DEFER_US_X10 = 32000;
   localparam int DEFER_CYC = (CLK_HZ / 1000000) * DEFER_US_X10 / 10;
   localparam int WINDOW_NS_X10 = 512000;
   localparam int CLK_NS = 20;
   localparam int WINDOW_CYC = WINDOW_NS_X10 / (10 * CLK_NS);
   localparam int MAX_COLL = 16;
   localparam int FCS_BYTES = 4;
endpackage

//--- src/tx_evt_if.sv
// Interface: transmit engine events passed from the control block to the timer module, and the expiry flag passed back
`timescale 1ns/100ps
interface tx_evt_if;
   logic start;
   logic defer_en;
   logic deferring;
   logic expired;
   modport ctl(output start, output defer_en, output deferring, input expired);
   modport tmr(input start, input defer_en, input deferring, output expired);
endinterface

//--- src/tx_defer_timer.sv
// Excessive deferral timer counting continuous deferral on the device clock
`timescale 1ns/100ps
module tx_defer_timer
   import tx_ctl_pkg::*;
#(
   parameter int DEFER_COUNT = DEFER_CYC
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Events
   tx_evt_if.tmr evt
);
   logic [17:0] cnt_r;
   logic [17:0] cnt_nxt;
   logic fired_r;
   // Counting stops when disabled so the flag can never rise then
   assign cnt_nxt = (evt.start || !evt.deferring || !evt.defer_en) ? 18'h00000 : cnt_r + 18'h00001;
   assign evt.expired = fired_r;
   // ==========================================
   // Counter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= 18'h00000;
         fired_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         fired_r <= evt.defer_en && evt.deferring && (cnt_r == 18'(DEFER_COUNT - 1));
      end
   end
endmodule

//--- src/tx_ctl_status.sv
// Transmit control and status register block with AXI4-Lite slave and interrupts
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/100ps
module tx_ctl_status
   import tx_ctl_pkg::*;
#(
   parameter int DEFER_COUNT = DEFER_CYC
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Transmit engine: descriptor and start
   input wire logic tx_start,
   input wire logic [15:0] descriptor_config_word,
   input wire logic soft_reset,
   // Transmit engine: line conditions
   input wire logic preamble_start,
   input wire logic sfd_done,
   input wire logic deferring,
   input wire logic collision,
   input wire logic carrier_seen,
   input wire logic carrier_dropped,
   input wire logic monitored_bad,
   input wire logic fifo_underrun,
   input wire logic byte_count_mismatch,
   input wire logic tx_end,
   input wire logic desc_written,
   // Transmit engine: controls back
   output logic tx_abort,
   output logic append_fcs,
   output logic [2:0] fcs_bytes,
   output logic backoff_req,
   output logic [20:0] descriptor_status_word,
   output logic status_wb_req,
   // Interrupt
   output logic irq
);
   // ==========================================
   // Declarations
   logic [15:0] tcs_r;
   logic [15:0] tcs_nxt;
   logic [4:0] coll_r;
   logic [11:0] win_r;
   logic win_run_r;
   logic wb_pend_r;
   logic [20:0] dsw_r;
   logic [N_IRQ-1:0] ist_r;
   logic [N_IRQ-1:0] ien_r;
   logic [N_IRQ-1:0] iset;
   logic [N_IRQ-1:0] iclr;
   logic abort_r;
   logic aw_got_r;
   logic w_got_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic wr_fire;
   logic rd_fire;
   logic [31:0] rd_word;
   logic rd_ok;
   logic wr_ok;
   logic host_mode_wr;
   logic late_coll;
   logic excess_coll;
   logic defer_exp;
   logic [15:0] cond_set;
   logic [7:0] rd_addr;
   logic wr_tcs_sel;
   logic wr_clr_sel;
   logic wr_en_sel;
   // Events shared with the deferral timer
   tx_evt_if evt();

   // Word address decode shared by read and write paths
   function automatic logic mapped(input logic [7:0] a);
      return (a == ADDR_TX_CTL) || (a == ADDR_IRQ_STATUS) || (a == ADDR_IRQ_CLEAR) ||
             (a == ADDR_IRQ_ENABLE) || (a == ADDR_TX_CMD) || (a == ADDR_DESC_STATUS);
   endfunction

   // ==========================================
   // Deferral timer
   // The timer restarts on every start so a stale count cannot abort the next packet
   assign evt.start = tx_start;
   assign evt.defer_en = !tcs_r[B_DEFDIS];
   assign evt.deferring = deferring;
   assign defer_exp = evt.expired;

   tx_defer_timer #(
      .DEFER_COUNT(DEFER_COUNT)
   ) u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .evt(evt)
   );

   // ==========================================
   // Collision logic
   // Window timer origin follows the captured mode bit
   // A slot time is thousands of cycles at this clock, so the counter needs twelve bits
   assign late_coll = collision && win_run_r && (win_r >= 12'(WINDOW_CYC));
   assign excess_coll = collision && (coll_r == 5'(MAX_COLL - 1));
   assign backoff_req = collision && !excess_coll;

   // Window counter and collision count
   // Both saturate so a very long packet cannot wrap back into the window
   always_ff @(posedge aclk) begin
      if (!aresetn || tx_start) begin
         win_r <= 12'h000;
         win_run_r <= 1'b0;
         coll_r <= 5'h00;
      end else begin
         if ((tcs_r[B_WINORG] && preamble_start) || (!tcs_r[B_WINORG] && sfd_done)) begin
            win_run_r <= 1'b1;
            win_r <= 12'h000;
         end else if (win_run_r && win_r != 12'hfff) begin
            win_r <= win_r + 12'h001;
         end
         if (collision && coll_r != 5'(MAX_COLL)) begin
            coll_r <= coll_r + 5'h01;
         end
      end
   end

   // ==========================================
   // Status register update
   // Conditions gathered while the packet is under way
   // Monitored bad means nothing without a checksum, so it is masked while inhibited
   assign cond_set = (16'(defer_exp) << B_EXDEF) | (16'(deferring) << B_DEFER) |
                     (16'(carrier_dropped) << B_CRSLOST) | (16'(excess_coll) << B_EXCOL) |
                     (16'(late_coll) << B_LATE) | (16'(monitored_bad && !tcs_r[B_FCSI]) << B_MONBAD) |
                     (16'(fifo_underrun) << B_UNDER) | (16'(byte_count_mismatch) << B_BCNT);
   // Write target decode; a refused write selects nothing
   assign wr_tcs_sel = wr_fire && wr_ok && (awaddr_r == ADDR_TX_CTL);
   assign wr_clr_sel = wr_fire && wr_ok && (awaddr_r == ADDR_IRQ_CLEAR);
   assign wr_en_sel = wr_fire && wr_ok && (awaddr_r == ADDR_IRQ_ENABLE);
   assign host_mode_wr = wr_tcs_sel && wstrb_r[1];

   // Priority: start, then packet events, then host mode write; set wins over clear
   always_comb begin
      tcs_nxt = tcs_r;
      if (host_mode_wr) begin
         tcs_nxt = (tcs_nxt & ~MODE_MASK) | (wdata_r[15:0] & MODE_MASK);
      end
      if (desc_written) begin
         tcs_nxt = tcs_nxt & ~CLR_AFTER_WB;
      end
      if (tx_start) begin
         tcs_nxt = (tcs_nxt & ~CLR_AT_START & ~MODE_MASK) | SET_AT_START |
                   (descriptor_config_word & MODE_MASK);
         tcs_nxt[B_TXOK] = 1'b0;
      end else begin
         tcs_nxt = tcs_nxt | cond_set;
         if (carrier_seen) begin
            tcs_nxt[B_NOCRS] = 1'b0;
         end
         if (tx_end) begin
            tcs_nxt[B_TXOK] = !(tcs_nxt[B_EXDEF] || tcs_nxt[B_EXCOL] || tcs_nxt[B_UNDER]);
         end
      end
      tcs_nxt = tcs_nxt & (MODE_MASK | STAT_MASK);
   end

   // Register; soft reset is deliberately not a term here
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tcs_r <= TX_CTL_RESET;
      end else begin
         tcs_r <= tcs_nxt;
      end
   end

   // ==========================================
   // Descriptor write back and abort
   // The status word is built from tcs_nxt so a flag raised in the end cycle is kept
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dsw_r <= 21'h000000;
         wb_pend_r <= 1'b0;
         abort_r <= 1'b0;
      end else begin
         abort_r <= (defer_exp && !tcs_r[B_DEFDIS]) || excess_coll;
         if (tx_end) begin
            dsw_r <= {coll_r, tcs_nxt & STAT_MASK};
            wb_pend_r <= 1'b1;
         end else if (desc_written) begin
            wb_pend_r <= 1'b0;
         end
      end
   end
   assign tx_abort = abort_r;
   assign descriptor_status_word = dsw_r;
   assign status_wb_req = wb_pend_r;
   // Frame check sequence controls seen by the engine
   assign append_fcs = !tcs_r[B_FCSI];
   assign fcs_bytes = tcs_r[B_FCSI] ? 3'h0 : 3'(FCS_BYTES);

   // ==========================================
   // Interrupts
   // Descriptor interrupt fires once on the rising mode bit, so alternate packets are needed
   assign iset[I_PROGRAMMABLE_TX_INTERRUPT] = tx_start && descriptor_config_word[B_PROGRAMMABLE_TX_INTERRUPT] && !tcs_r[B_PROGRAMMABLE_TX_INTERRUPT];
   assign iset[I_DONE] = tx_end;
   assign iset[I_ABORT] = abort_r;
   assign iclr = wr_clr_sel ? wdata_r[N_IRQ-1:0] : '0;
   assign irq = |(ist_r & ien_r);

   // Sticky status; an event that meets a clear write in one cycle wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ist_r <= '0;
         ien_r <= '0;
      end else begin
         ist_r <= (ist_r & ~iclr) | iset;
         if (wr_en_sel) begin
            ien_r <= wdata_r[N_IRQ-1:0];
         end
      end
   end

   // ==========================================
   // AXI4-Lite write path
   // Both channels stall while a response is pending, so one write is under way
   assign s_axi_awready = !aw_got_r && !bvalid_r;
   assign s_axi_wready = !w_got_r && !bvalid_r;
   assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
   assign wr_ok = mapped(awaddr_r);
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   // Address and data may come in either order; each is latched once until the response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_ok ? 2'h0 : 2'h2;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // ==========================================
   // AXI4-Lite read path
   // Read data is looked up in the cycle the address is taken and held in rdata_r
   assign s_axi_arready = !rvalid_r;
   assign rd_fire = s_axi_arvalid && !rvalid_r;
   assign rd_addr = {s_axi_araddr[7:2], 2'b00};
   assign rd_ok = mapped(rd_addr);

   // Read mux; the clear register is write-only and reads as zero like an unmapped word
   always_comb begin
      rd_word = 32'h00000000;
      if (rd_addr == ADDR_TX_CTL) begin
         rd_word = {16'h0000, tcs_r};
      end else if (rd_addr == ADDR_IRQ_STATUS) begin
         rd_word = {29'h0, ist_r};
      end else if (rd_addr == ADDR_IRQ_ENABLE) begin
         rd_word = {29'h0, ien_r};
      end else if (rd_addr == ADDR_TX_CMD) begin
         rd_word = {31'h0, soft_reset};
      end else if (rd_addr == ADDR_DESC_STATUS) begin
         rd_word = {11'h000, dsw_r};
      end
   end
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // rvalid stands until rready; no new address is taken meanwhile
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= 2'h0;
      end else if (rd_fire) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_word;
         rresp_r <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end
endmodule

//--- dv/tx_ctl_status_assertions.sv
// Checker: port-level assertions for the transmit control block
`timescale 1ns/100ps
module tx_ctl_status_assertions
   import tx_ctl_pkg::*;
#(
   parameter int DEFER_COUNT = DEFER_CYC
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus answers
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Engine side
   input wire logic tx_start,
   input wire logic [15:0] descriptor_config_word,
   input wire logic deferring,
   input wire logic collision,
   input wire logic tx_end,
   input wire logic desc_written,
   input wire logic tx_abort,
   input wire logic append_fcs,
   input wire logic [2:0] fcs_bytes,
   input wire logic backoff_req,
   input wire logic [20:0] descriptor_status_word,
   input wire logic status_wb_req
);
   // ==========
   // Helper state
   logic dis_r;
   logic [4:0] coll_r;
   logic [17:0] def_r;
   // Mode, collision tally and deferral run; counters saturate so they never wrap
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dis_r <= 1'b0;
         coll_r <= 5'h00;
         def_r <= 18'h00000;
      end else begin
         if (tx_start) begin
            dis_r <= descriptor_config_word[B_DEFDIS];
         end
         coll_r <= tx_start ? 5'h00 : coll_r + 5'(collision && coll_r != 5'h1f);
         def_r <= deferring ? def_r + 18'(def_r != 18'h3ffff) : 18'h00000;
      end
   end
   // ==========
   // Properties
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wb_wait;
      status_wb_req && !desc_written;
   endsequence
   sequence s_last_coll;
      collision && coll_r == 5'h0f;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // Two cycles of slack on the deferral figure cover the registered abort
   chk_abort_cause: assert property ($rose(tx_abort) |->
      coll_r == 5'h10 || (!dis_r && def_r >= DEFER_COUNT - 2))
      else $error("abort without a cause");
   chk_excol_abort: assert property (s_last_coll |=> tx_abort)
      else $error("no abort after sixteenth collision");
   chk_backoff_rule: assert property (collision |-> backoff_req == (coll_r != 5'h0f))
      else $error("backoff request wrong");
   chk_fcs_mode: assert property (tx_start |=> append_fcs == !$past(descriptor_config_word[B_FCSI]))
      else $error("fcs append does not follow mode");
   chk_fcs_len: assert property (append_fcs |-> fcs_bytes == 3'h4)
      else $error("fcs length not four");
   chk_wb_start: assert property (tx_end |=> status_wb_req)
      else $error("no writeback request after end");
   chk_wb_hold: assert property (s_wb_wait |=> status_wb_req)
      else $error("writeback request dropped early");
   chk_resv_zero: assert property (tx_end |=> !descriptor_status_word[11] && !descriptor_status_word[4])
      else $error("reserved status bits set");
   chk_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
      else $error("read answer late");
   chk_rd_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer repeated");
   chk_wr_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
endmodule

bind tx_ctl_status tx_ctl_status_assertions #(.DEFER_COUNT(DEFER_COUNT)) u_chk (
   .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid,
   .s_axi_bready, .tx_start, .descriptor_config_word, .deferring, .collision, .tx_end, .desc_written,
   .tx_abort, .append_fcs, .fcs_bytes, .backoff_req, .descriptor_status_word, .status_wb_req
);

//--- dv/tx_ctl_status_tb.sv
// Testbench: register access, packet status flow and interrupts of the transmit control block
`timescale 1ns/100ps
module tx_ctl_status_tb;
   import tx_ctl_pkg::*;
   // ==========
   // Signals
   localparam int DC = 20;
   localparam logic [9:0] E_START = 10'h200, E_PRE = 10'h100, E_SFD = 10'h080, E_DEFER = 10'h040;
   localparam logic [9:0] E_COLL = 10'h020, E_DROP = 10'h010, E_MON = 10'h008, E_BYTE = 10'h004;
   localparam logic [9:0] E_END = 10'h002, E_WB = 10'h001;
   logic aclk = 0, aresetn = 0, soft_reset = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [15:0] descriptor_config_word = 0;
   logic [9:0] ev = 0;
   logic tx_start, preamble_start, sfd_done, deferring, collision, carrier_dropped, monitored_bad;
   logic byte_count_mismatch, tx_end, desc_written, tx_abort, append_fcs, backoff_req, status_wb_req, irq;
   logic [2:0] fcs_bytes;
   logic [20:0] descriptor_status_word;
   int tests_run = 0, bad_count = 0, aborts = 0, a0;
   assign {tx_start, preamble_start, sfd_done, deferring, collision, carrier_dropped, monitored_bad,
      byte_count_mismatch, tx_end, desc_written} = ev;
   // Clock, and a tally of abort cycles for the timer checks
   always #10 aclk = ~aclk;
   always @(posedge aclk) if (tx_abort === 1'b1) aborts++;
   tx_ctl_status #(.DEFER_COUNT(DC)) u_tx_ctl_status (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_start,
      .descriptor_config_word, .soft_reset, .preamble_start, .sfd_done, .deferring, .collision,
      .carrier_seen(1'b0), .carrier_dropped, .monitored_bad, .fifo_underrun(1'b0), .byte_count_mismatch,
      .tx_end, .desc_written, .tx_abort, .append_fcs, .fcs_bytes, .backoff_req, .descriptor_status_word,
      .status_wb_req, .irq
   );
   // ==========
   // Shared tasks
   task automatic eq(input logic [31:0] got, input logic [31:0] exp, input string m);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask
   // Write: both channels offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   // Read with masked compare of the returned word
   task automatic rc(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp, input string m);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      r = s_axi_rresp;
      s_axi_rready <= 0;
      eq(s_axi_rdata & mask, exp, m);
   endtask
   // Engine events held for n cycles; ends off-edge so outputs have settled
   task automatic go(input logic [9:0] v, input int n);
      @(posedge aclk);
      ev <= v;
      repeat (n) @(posedge aclk);
      ev <= 0;
      @(negedge aclk);
   endtask
   task automatic start(input logic [15:0] c);
      @(posedge aclk);
      descriptor_config_word <= c;
      go(E_START, 1);
   endtask
   // ==========
   // Scenarios
   task automatic t_regs;
      rc(ADDR_TX_CTL, 32'hffff, 32'h0101, "reset value");
      eq(irq, 0, "irq after reset");
      wr(ADDR_TX_CTL, 32'hffff);
      rc(ADDR_TX_CTL, 32'hffffffff, 32'hf101, "only mode bits writable");
      @(posedge aclk);
      soft_reset <= 1;
      rc(ADDR_TX_CTL, 32'hffff, 32'hf101, "soft reset changed register");
      rc(ADDR_TX_CMD, 32'h1, 32'h1, "soft reset level not visible");
      wr(ADDR_TX_CTL, 32'h0);
      soft_reset <= 0;
      wr(8'hfc, 32'h1);
      eq(r, 2, "unmapped write not refused");
      rc(8'hfc, 32'hffffffff, 0, "unmapped read not zero");
      eq(r, 2, "unmapped read not refused");
      $display("test regs done");
   endtask
   task automatic t_good_packet;
      wr(ADDR_IRQ_ENABLE, 32'h1 << I_PROGRAMMABLE_TX_INTERRUPT);
      start(16'ha000);
      eq(append_fcs, 0, "fcs not inhibited");
      eq(irq, 1, "descriptor interrupt missing");
      go(E_PRE, 1);
      go(E_SFD, 1);
      go(E_DEFER, 1);
      go(E_COLL, 1);
      go(E_COLL, 1);
      go(E_MON, 1);
      go(E_END, 1);
      eq(status_wb_req, 1, "no writeback request");
      // Checksum is inhibited in this packet, so monitored bad must stay clear
      eq(descriptor_status_word & 21'h1f0fff, {5'd2, 16'h0301}, "status word");
      go(E_WB, 1);
      rc(ADDR_TX_CTL, 32'hffff, 32'ha101, "mode kept, bit 9 cleared");
      wr(ADDR_IRQ_ENABLE, 32'h0);
      eq(irq, 0, "masked interrupt still high");
      rc(ADDR_IRQ_STATUS, 32'h1, 32'h1, "interrupt flag");
      wr(ADDR_IRQ_CLEAR, 32'h1);
      rc(ADDR_IRQ_STATUS, 32'h1, 32'h0, "interrupt flag not cleared");
      wr(ADDR_TX_CTL, 32'h0);
      $display("test good packet done");
   endtask
   task automatic t_abort_packet;
      start(16'h0000);
      repeat (MAX_COLL) go(E_COLL, 1);
      a0 = aborts;
      go(E_DEFER, DC + 4);
      go(E_DROP, 1);
      go(E_BYTE, 1);
      go(E_END, 1);
      eq(aborts > a0, 1, "no deferral abort");
      eq(descriptor_status_word & 21'h1f06c2, {5'd16, 16'h06c2}, "abort status word");
      go(E_WB, 1);
      rc(ADDR_IRQ_STATUS, 32'h6, 32'h6, "done and abort interrupt flags");
      start(16'h0000);
      rc(ADDR_TX_CTL, 32'h05c2, 32'h0100, "start did not clear flags");
      $display("test abort packet done");
   endtask
   // Collision after the window counted from preamble but not from the delimiter
   task automatic t_window(input logic [15:0] c, input logic late);
      start(c);
      go(E_PRE, 1);
      a0 = aborts;
      go(E_DEFER, DC + 4);
      eq(aborts != a0, !c[B_DEFDIS], "deferral abort");
      repeat (WINDOW_CYC + 4) @(posedge aclk);
      go(E_SFD, 1);
      go(E_COLL, 1);
      go(E_MON, 1);
      go(E_END, 1);
      eq(descriptor_status_word[B_EXDEF], !c[B_DEFDIS], "excessive deferral flag");
      eq(descriptor_status_word[B_LATE], late, "late collision flag");
      eq(descriptor_status_word[B_MONBAD], 1, "monitored bad flag");
      go(E_WB, 1);
      $display("test window done");
   endtask
   // ==========
   // Sequence and verdict
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      t_regs;
      t_good_packet;
      t_abort_packet;
      t_window(16'h5000, 1);
      t_window(16'h0000, 0);
      tally_and_finish;
   end
   // Watchdog well beyond the two window waits
   initial begin
      #400000;
      bad_count++;
      tally_and_finish;
   end
endmodule
